// ==== dv/tb_azmu_unit.sv ====
`timescale 1ns/10ps
`include "azmu_map.svh"

module tb_azmu_unit;
   logic                 core_clk = 1'b0;
   logic                 sys_rst = 1'b1;
   logic                 psel = 1'b0;
   logic                 penable = 1'b0;
   logic                 pwrite = 1'b0;
   logic [11:0]          paddr = 12'h000;
   logic [31:0]          pwdata = 32'h0;
   logic [3:0]           pstrb = 4'h1;
   logic                 pready;
   logic [31:0]          prdata;
   logic                 pslverr;
   azmu_pkg::azmu_time_s timeIn = '0;
   logic                 timeUpdate = 1'b0;
   logic                 tuOnAcc = 1'b0;
   logic                 alarm0MatchFlag;
   logic                 irq;
   int                   errors = 0;
   int                   comparisons = 0;
   logic [31:0]          rd;
   logic                 err;
   logic                 mk;
   logic [6:0]           mSec, mMin;
   logic [5:0]           mHour, mDate;
   logic [2:0]           mWday;
   azmu_pkg::azmu_time_s hitT, missT;

   always #2.5 core_clk = ~core_clk;

   azmu_unit dut (.core_clk(core_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
      .prdata(prdata), .pslverr(pslverr), .timeIn(timeIn), .timeUpdate(timeUpdate),
      .alarm0MatchFlag(alarm0MatchFlag), .irq(irq));

   task automatic final_report;
      $display("errors=%0d comparisons=%0d", errors, comparisons);
      if (errors == 0 && comparisons > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         errors++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic chk1(input logic got, input logic exp);
      comparisons++;
      if (got !== exp) begin
         errors++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Upper write lanes carry noise; only the low byte may land.
   task automatic apb(input logic wr, input logic [9:0] idx, input logic [7:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= {idx, 2'b00};
      pwdata <= {24'($urandom), d};
      @(posedge core_clk);
      penable <= 1'b1;
      timeUpdate <= tuOnAcc;
      do begin
         @(posedge core_clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         errors++;
         final_report();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      timeUpdate <= 1'b0;
      @(posedge core_clk);
   endtask

   task automatic wrrd(input logic [9:0] idx, input logic [7:0] d, input logic [31:0] exp);
      apb(1'b1, idx, d);
      apb(1'b0, idx, 8'h00);
      chk32(rd, exp);
   endtask

   // A hit is cleared afterwards so that each update is judged on its own.
   task automatic upd(input azmu_pkg::azmu_time_s t, input logic exp, input logic [2:0] c);
      timeIn <= t;
      timeUpdate <= 1'b1;
      @(posedge core_clk);
      timeUpdate <= 1'b0;
      @(posedge core_clk);
      chk1(alarm0MatchFlag, exp);
      chk1(irq, exp & mk);
      apb(1'b0, `AZMU_IDX_STAT, 8'h00);
      chk32(rd, {31'h0, exp});
      if (exp) begin
         apb(1'b1, `AZMU_IDX_WDAY, {1'b0, c, 1'b0, mWday});
         apb(1'b1, `AZMU_IDX_STAT, 8'h01);
      end
   endtask

   function automatic logic [6:0] bcd(input int t);
      return {3'($urandom % t), 4'($urandom % 10)};
   endfunction

   // ==========================================================
   // Main sequence
   initial begin
      void'($urandom(32'hbad9));
      repeat (5) @(posedge core_clk);
      sys_rst <= 1'b0;
      @(posedge core_clk);
      apb(1'b0, `AZMU_IDX_WDAY, 8'h00);
      chk32(rd, 32'h0);
      chk1(irq, 1'b0);
      apb(1'b0, 10'h3ff, 8'h00);
      chk1(err, 1'b1);
      chk32(rd, 32'h0);
      wrrd(`AZMU_IDX_SEC, 8'hff, 32'h7f);
      wrrd(`AZMU_IDX_MIN, 8'hff, 32'h7f);
      wrrd(`AZMU_IDX_DATE, 8'hff, 32'h3f);
      timeIn.hour <= 7'h40;
      wrrd(`AZMU_IDX_HOUR, 8'hbf, 32'h7f);
      timeIn.hour <= 7'h00;
      pstrb <= 4'h0;
      apb(1'b1, `AZMU_IDX_SEC, 8'h00);
      pstrb <= 4'h1;
      apb(1'b0, `AZMU_IDX_SEC, 8'h00);
      chk32(rd, 32'h7f);
      mk = 1'b1;
      apb(1'b1, `AZMU_IDX_MASK, 8'h01);
      apb(1'b1, `AZMU_IDX_CTRL, 8'h10);
      for (int c = 0; c < 5; c++) begin
         mSec = bcd(6);
         mMin = bcd(6);
         mHour = 6'(bcd(2));
         mDate = 6'(bcd(3));
         mWday = 3'($urandom % 7 + 1);
         wrrd(`AZMU_IDX_SEC, {1'b0, mSec}, {25'h0, mSec});
         wrrd(`AZMU_IDX_MIN, {1'b0, mMin}, {25'h0, mMin});
         wrrd(`AZMU_IDX_HOUR, {2'b0, mHour}, {26'h0, mHour});
         wrrd(`AZMU_IDX_DATE, {2'b0, mDate}, {26'h0, mDate});
         wrrd(`AZMU_IDX_WDAY, {1'b0, 3'(c), 1'b0, mWday}, {25'h0, 3'(c), 1'b0, mWday});
         hitT = {mSec, mMin, {1'b0, mHour}, mWday, mDate};
         if (c == 3) begin
            hitT.sec = 7'h00;
            hitT.min = 7'h00;
            hitT.hour = 7'h00;
         end
         missT = hitT;
         case (c)
            0: missT.sec = hitT.sec ^ 7'h01;
            1: missT.min = hitT.min ^ 7'h01;
            2: missT.hour = hitT.hour ^ 7'h01;
            3: missT.hour = 7'h01;
            default: missT.date = hitT.date ^ 6'h01;
         endcase
         upd(missT, 1'b0, 3'(c));
         upd(hitT, 1'b1, 3'(c));
         upd(hitT, 1'b0, 3'(c));
      end
      // Twelve-hour clock: noon must not pass for midnight.
      apb(1'b1, `AZMU_IDX_WDAY, {1'b0, 3'd3, 1'b0, mWday});
      hitT = {7'h00, 7'h00, 7'h52, mWday, mDate};
      missT = hitT;
      missT.hour = 7'h72;
      upd(missT, 1'b0, 3'd3);
      upd(hitT, 1'b1, 3'd3);
      for (int e = 0; e < 4; e++) begin
         apb(1'b1, `AZMU_IDX_CTRL, {2'b0, 2'(e), 4'h0});
         upd(missT, 1'b0, 3'd3);
         upd(hitT, e[0], 3'd3);
      end
      mk = 1'b0;
      apb(1'b1, `AZMU_IDX_MASK, 8'h00);
      upd(missT, 1'b0, 3'd3);
      upd(hitT, 1'b1, 3'd3);
      upd(missT, 1'b0, 3'd3);
      // A clearing write in the very cycle of a new match must lose to the match.
      tuOnAcc = 1'b1;
      timeIn <= hitT;
      apb(1'b1, `AZMU_IDX_WDAY, {1'b0, 3'd3, 1'b0, mWday});
      tuOnAcc = 1'b0;
      chk1(alarm0MatchFlag, 1'b1);
      apb(1'b1, `AZMU_IDX_WDAY, {1'b0, 3'd3, 1'b1, mWday});
      apb(1'b0, `AZMU_IDX_WDAY, 8'h00);
      chk32(rd, {25'h0, 3'd3, 1'b1, mWday});
      apb(1'b1, `AZMU_IDX_WDAY, {1'b0, 3'd5, 1'b0, mWday});
      apb(1'b0, `AZMU_IDX_STAT, 8'h00);
      chk32(rd, 32'h3);
      apb(1'b1, `AZMU_IDX_STAT, 8'h03);
      upd(missT, 1'b0, 3'd5);
      upd(hitT, 1'b0, 3'd5);
      final_report();
   end
endmodule

// ==== verilog/azmu_map.svh ====
// How it works
// - Seconds match holds BCD tens in bits 6-4, units in bits 3-0.
// - Minutes match holds 3-bit BCD tens above 4-bit units, top bit unused.
// - Hours match bit 6 mirrors time format bit; bits 5-0 hold the hour.
// - Condition bits 6-4 pick seconds, minutes, hours, weekday or date.
// - Match sets the flag in bit 3; software clears it by writing zero there.
// - Weekday match value sits in bits 2-0, range one to seven.
// - Date match holds tens in bits 5-4, units 3-0; bits 7-6 read zero.
// - Two-bit enable field gates alarms; alarm zero needs its bit set.
`ifndef AZMU_MAP_SVH
`define AZMU_MAP_SVH

// ==========================================================
// Register indices, byte address is four times the index
`define AZMU_IDX_CTRL   10'h008
`define AZMU_IDX_SEC    10'h00c
`define AZMU_IDX_MIN    10'h00d
`define AZMU_IDX_HOUR   10'h00e
`define AZMU_IDX_WDAY   10'h00f
`define AZMU_IDX_DATE   10'h010
`define AZMU_IDX_STAT   10'h018
`define AZMU_IDX_MASK   10'h019

// ==========================================================
// Field positions and constants
`define AZMU_EN_LSB     4
`define AZMU_COND_LSB   4
`define AZMU_FLAG_BIT   3
`define AZMU_HFMT_BIT   6
`define AZMU_ST_MATCH   0
`define AZMU_ST_BADCOND 1
`define AZMU_MID_12H    6'h12
`define AZMU_MID_24H    6'h00

`endif

// ==== verilog/azmu_pkg.sv ====
package azmu_pkg;

   // Condition codes take their implicit values 0 to 4.
   typedef enum logic [2:0] {
      CondSec,
      CondMin,
      CondHour,
      CondWday,
      CondDate
   } azmu_cond_e;

   // Running time from the timekeeping counters, BCD apart from hour bit 6, the format bit.
   typedef struct packed {
      logic [6:0] sec;
      logic [6:0] min;
      logic [6:0] hour;
      logic [2:0] wday;
      logic [5:0] date;
   } azmu_time_s;

   // Stored match values.
   typedef struct packed {
      logic [6:0] sec;
      logic [6:0] min;
      logic [5:0] hour;
      logic [2:0] cond;
      logic       flag;
      logic [2:0] wday;
      logic [5:0] date;
   } azmu_match_s;

endpackage

// ==== verilog/azmu_unit.sv ====
// Register access over APB was chosen for this implementation.
`timescale 1ns/10ps
`include "azmu_map.svh"

module azmu_unit #(
   parameter int ADDR_W = 12
) (
   // Clock and reset
   input  wire logic                  core_clk,
   input  wire logic                  sys_rst,
   // APB slave
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [ADDR_W-1:0]     paddr,
   input  wire logic [31:0]           pwdata,
   input  wire logic [3:0]            pstrb,
   output logic                       pready,
   output logic [31:0]                prdata,
   output logic                       pslverr,
   // Timekeeping counters
   input  wire azmu_pkg::azmu_time_s  timeIn,
   input  wire logic                  timeUpdate,
   // Alarm outputs
   output logic                       alarm0MatchFlag,
   output logic                       irq
);

   // ==========================================================
   // Bus decode
   logic [9:0]  regIdx;
   logic        setupRd;
   logic        accWr;
   logic        mapped;
   logic        wrLane0;

   assign regIdx  = paddr[11:2];
   assign setupRd = psel && !penable && !pwrite;
   assign accWr   = psel && penable && pwrite && mapped;
   assign wrLane0 = pstrb[0];

   always_comb begin
      case (regIdx)
         `AZMU_IDX_CTRL, `AZMU_IDX_SEC, `AZMU_IDX_MIN, `AZMU_IDX_HOUR,
         `AZMU_IDX_WDAY, `AZMU_IDX_DATE, `AZMU_IDX_STAT,
         `AZMU_IDX_MASK: mapped = 1'b1;
         default: mapped = 1'b0;
      endcase
   end

   // Zero wait states keep the master simple and the timing fixed.
   assign pready  = 1'b1;
   assign pslverr = psel && penable && !mapped;

   // ==========================================================
   // Register state
   azmu_pkg::azmu_match_s mr;
   azmu_pkg::azmu_match_s next_mr;
   logic [1:0]  almEn;
   logic [1:0]  next_almEn;
   logic [1:0]  status;
   logic [1:0]  next_status;
   logic [1:0]  mask;
   logic [1:0]  next_mask;
   logic        lastHit;
   logic        next_lastHit;
   logic [31:0] next_prdata;

   // ==========================================================
   // Match logic
   logic        midnight;
   logic        fieldHit;
   logic        hit;
   logic        matchEvent;
   logic        badCondWr;

   // Midnight differs by format: 12 AM in 12-hour, 00 in 24-hour.
   // midnight per format
   always_comb begin
      midnight = (timeIn.sec == 7'h00) && (timeIn.min == 7'h00);
      if (timeIn.hour[`AZMU_HFMT_BIT]) begin
         midnight = midnight && (timeIn.hour[5:0] == `AZMU_MID_12H);
      end else begin
         midnight = midnight && (timeIn.hour[5:0] == `AZMU_MID_24H);
      end
   end

   always_comb begin
      case (azmu_pkg::azmu_cond_e'(mr.cond))
         azmu_pkg::CondSec:  fieldHit = (mr.sec == timeIn.sec);
         azmu_pkg::CondMin:  fieldHit = (mr.min == timeIn.min);
         azmu_pkg::CondHour: fieldHit = (mr.hour == timeIn.hour[5:0]);
         azmu_pkg::CondWday: fieldHit = (mr.wday == timeIn.wday) && midnight;
         azmu_pkg::CondDate: fieldHit = (mr.date == timeIn.date);
         default:            fieldHit = 1'b0;
      endcase
   end

   assign hit = fieldHit && almEn[0];

   // Edge detection stops a long-lasting equality from firing on
   // every update; only the first matching update counts.
   // once per matching instant
   assign matchEvent   = timeUpdate && hit && !lastHit;
   assign next_lastHit = timeUpdate ? hit : lastHit;

   assign badCondWr = accWr && wrLane0 && (regIdx == `AZMU_IDX_WDAY)
                      && (pwdata[6:4] > 3'h4);

   // ==========================================================
   // Register writes
   always_comb begin
      next_mr     = mr;
      next_almEn  = almEn;
      next_mask   = mask;
      next_status = status;
      if (accWr && wrLane0) begin
         case (regIdx)
            `AZMU_IDX_CTRL: next_almEn = pwdata[`AZMU_EN_LSB+:2];
            `AZMU_IDX_SEC:  next_mr.sec = pwdata[6:0];
            `AZMU_IDX_MIN:  next_mr.min = pwdata[6:0];
            `AZMU_IDX_HOUR: next_mr.hour = pwdata[5:0];
            `AZMU_IDX_WDAY: begin
               next_mr.cond = pwdata[`AZMU_COND_LSB+:3];
               next_mr.wday = pwdata[2:0];
               if (!pwdata[`AZMU_FLAG_BIT]) begin
                  next_mr.flag = 1'b0;
               end
            end
            `AZMU_IDX_DATE: next_mr.date = pwdata[5:0];
            `AZMU_IDX_STAT: next_status = status & ~pwdata[1:0];
            `AZMU_IDX_MASK: next_mask = pwdata[1:0];
            default: next_mask = mask;
         endcase
      end
      // Hardware set is applied last so it wins over a same-cycle clear.
      // match sets flag
      if (matchEvent) begin
         next_mr.flag = 1'b1;
         next_status[`AZMU_ST_MATCH] = 1'b1;
      end
      if (badCondWr) begin
         next_status[`AZMU_ST_BADCOND] = 1'b1;
      end
   end

   // ==========================================================
   // Read data, captured in the setup phase
   always_comb begin
      next_prdata = prdata;
      if (setupRd) begin
         next_prdata = 32'h0000_0000;
         case (regIdx)
            `AZMU_IDX_CTRL: next_prdata[`AZMU_EN_LSB+:2] = almEn;
            `AZMU_IDX_SEC:  next_prdata[6:0] = mr.sec;
            `AZMU_IDX_MIN:  next_prdata[6:0] = mr.min;
            `AZMU_IDX_HOUR: next_prdata[6:0] = {timeIn.hour[`AZMU_HFMT_BIT], mr.hour};
            `AZMU_IDX_WDAY: next_prdata[6:0] = {mr.cond, mr.flag, mr.wday};
            `AZMU_IDX_DATE: next_prdata[5:0] = mr.date;
            `AZMU_IDX_STAT: next_prdata[1:0] = status;
            `AZMU_IDX_MASK: next_prdata[1:0] = mask;
            default:        next_prdata = 32'h0000_0000;
         endcase
      end
   end

   // ==========================================================
   // Flip-flops
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         mr      <= '0;
         almEn   <= 2'h0;
         status  <= 2'h0;
         mask    <= 2'h0;
         lastHit <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else begin
         mr      <= next_mr;
         almEn   <= next_almEn;
         status  <= next_status;
         mask    <= next_mask;
         lastHit <= next_lastHit;
         prdata  <= next_prdata;
      end
   end

   assign alarm0MatchFlag = mr.flag;
   assign irq             = |(status & mask);

   // ==========================================================
   // Assertions
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);

   a_flag_on_match: assert property (
      timeUpdate && hit && !lastHit |=> alarm0MatchFlag && status[0])
      else $error("Flag not set after a new match.");

   a_enable_gates_fire: assert property (
      $rose(alarm0MatchFlag) |-> $past(almEn[0]) && $past(timeUpdate))
      else $error("Flag rose without enable or update.");

   a_single_fire: assert property (
      timeUpdate && hit && lastHit && !accWr
      |=> alarm0MatchFlag == $past(alarm0MatchFlag))
      else $error("Match fired twice for one instant.");

   a_flag_clear_write: assert property (
      accWr && wrLane0 && regIdx == `AZMU_IDX_WDAY && !pwdata[3] && !matchEvent
      |=> !alarm0MatchFlag)
      else $error("Flag not cleared by write.");

   a_set_beats_clear: assert property (
      matchEvent |=> alarm0MatchFlag ##0 status[0])
      else $error("Same-cycle clear lost the event.");

   a_date_top_zero: assert property (
      setupRd && regIdx == `AZMU_IDX_DATE |=> prdata[31:6] == 26'h0)
      else $error("Date bits 7-6 not zero.");

   a_bit7_zero: assert property (
      setupRd && regIdx inside {`AZMU_IDX_SEC, `AZMU_IDX_MIN, `AZMU_IDX_HOUR}
      |=> prdata[7] == 1'b0)
      else $error("Unused bit 7 read as one.");

   a_hour_fmt_copy: assert property (
      setupRd && regIdx == `AZMU_IDX_HOUR |=> prdata[6] == $past(timeIn.hour[6]))
      else $error("Hour format copy wrong.");

   a_wday_midnight: assert property (
      timeUpdate && almEn[0] && !lastHit && mr.cond == 3'h3
      && mr.wday == timeIn.wday && midnight |=> alarm0MatchFlag)
      else $error("Weekday match missed at midnight.");

   a_irq_follows: assert property (
      matchEvent && mask[0] && !(accWr && wrLane0 && regIdx == `AZMU_IDX_MASK) |=> irq)
      else $error("Interrupt not raised for masked-in event.");

endmodule
